// ==== csr_pkg.sv ====
`default_nettype none
package csr_pkg;
   localparam logic [4:0]  REG_SAVED_EXC_PC   = 5'h00;
   localparam logic [4:0]  REG_SAVED_EXC_PSW  = 5'h01;
   localparam logic [4:0]  REG_SAVED_NMI_PC   = 5'h02;
   localparam logic [4:0]  REG_SAVED_NMI_PSW  = 5'h03;
   localparam logic [4:0]  REG_CAUSE          = 5'h04;
   localparam logic [4:0]  REG_PSW            = 5'h05;
   localparam logic [31:0] CAUSE_RESET        = 32'h0000_0000;
   localparam logic [7:0]  PSW_RESET          = 8'h20;
   localparam logic [31:0] SAVED_RESET        = 32'h0000_0000;
   localparam int          PSW_NMI_SRV        = 7;
   localparam int          PSW_EXC_SRV        = 6;
   localparam int          PSW_IRQ_BLK        = 5;
   localparam int          PSW_STICKY_SAT     = 4;
   localparam int          PSW_CARRY          = 3;
   localparam int          PSW_OVF            = 2;
   localparam int          PSW_S              = 1;
   localparam int          PSW_Z              = 0;
   localparam int          PSW_WIDTH          = 8;
   localparam int          CAUSE_NMI_LSB      = 16;
   localparam logic [31:0] SAT_MAX_POS        = 32'h7fff_ffff;
   localparam logic [31:0] SAT_MIN_NEG        = 32'h8000_0000;
   typedef enum logic [3:0]
   {
      EV_NONE = 4'h1,
      EV_EXC  = 4'h2,
      EV_INT  = 4'h4,
      EV_NMI  = 4'h8
   } csr_event_t;
endpackage
`default_nettype wire

// ==== csr_sat.sv ====
`timescale 1ns/1ps
`default_nettype none
module csr_sat
(
   input  wire logic        ovf_i,
   input  wire logic        sign_i,
   input  wire logic [31:0] raw_i,
   output var  logic [31:0] res_o,
   output var  logic        sign_o
);
   // Clamp from overflow and sign of the true result
   always_comb
   begin
      if (ovf_i && !sign_i)
      begin
         res_o  = csr_pkg::SAT_MAX_POS;
         sign_o = 1'b0;
      end
      else if (ovf_i && sign_i)
      begin
         res_o  = csr_pkg::SAT_MIN_NEG;
         sign_o = 1'b1;
      end
      else
      begin
         res_o  = raw_i;
         sign_o = raw_i[31];
      end
   end
endmodule
`default_nettype wire

// ==== csr_rdmux.sv ====
`timescale 1ns/1ps
`default_nettype none
module csr_rdmux
(
   input  wire logic [4:0]  sel_i,
   input  wire logic [31:0] exc_pc_i,
   input  wire logic [31:0] exc_psw_i,
   input  wire logic [31:0] nmi_pc_i,
   input  wire logic [31:0] nmi_psw_i,
   input  wire logic [31:0] cause_i,
   input  wire logic [7:0]  psw_i,
   output var  logic [31:0] data_o
);
   always_comb
   begin
      case (sel_i)
         csr_pkg::REG_SAVED_EXC_PC:  data_o = exc_pc_i;
         csr_pkg::REG_SAVED_EXC_PSW: data_o = exc_psw_i;
         csr_pkg::REG_SAVED_NMI_PC:  data_o = nmi_pc_i;
         csr_pkg::REG_SAVED_NMI_PSW: data_o = nmi_psw_i;
         csr_pkg::REG_CAUSE:         data_o = cause_i;
         csr_pkg::REG_PSW:           data_o = {24'h00_0000, psw_i};
         default:                    data_o = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// ==== csr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Numbers 0-5 select saved exc PC/PROGRAM_STATUS_WORD, saved NMI PC/PROGRAM_STATUS_WORD, cause, status; rest reserved.
// - Registers are reached only by the load and store system register instructions.
// - Exception or maskable interrupt copies PC and status into the saved exception pair.
// - NMI copies PC and status into the separate saved NMI pair.
// - Cause gets NMI code in bits 31:16, exception/interrupt code in 15:0.
// - Status bits 31:8 read zero and ignore writes.
// - Bit 7 set on NMI acknowledge; blocks further interrupt nesting while set.
// - Bit 6 set on exception; interrupts stay acknowledgeable while set.
// - Bit 5 blocks maskable interrupts; set on maskable acknowledge.
// - Bit 4 is sticky saturation; only a direct status write clears it.
// - Bit 3 shows carry or borrow of the operation.
// - Bit 2 shows overflow of the operation.
// - Bit 1 shows a negative result.
// - Bit 0 shows a zero result.
// - Saturating overflow also sets sticky saturation; clamp chosen by overflow and sign.
// - Positive overflow: set saturation and overflow, clear sign, return maximum positive.
// - Negative overflow: set saturation, overflow, sign, return minimum negative.
// - In range: keep saturation, clear overflow, sign from result, return result.
module csr_regs
(
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        SREG_LOAD_I,
   input  wire logic        SREG_STORE_I,
   input  wire logic [4:0]  REG_NUM_I,
   input  wire logic [31:0] WDATA_I,
   output logic      [31:0] RDATA_O,
   output logic             RVALID_O,
   input  wire logic        EXC_TAKE_I,
   input  wire logic        INT_REQ_I,
   input  wire logic        NMI_REQ_I,
   input  wire logic [15:0] EVENT_CODE_I,
   input  wire logic [31:0] PC_I,
   input  wire logic        FLAG_UPD_I,
   input  wire logic        SAT_OP_I,
   input  wire logic [31:0] ALU_RES_I,
   input  wire logic        ALU_CY_I,
   input  wire logic        ALU_OV_I,
   input  wire logic        ALU_SIGN_I,
   output logic      [31:0] SAT_RES_O,
   output logic             INT_ACK_O,
   output logic             NMI_ACK_O,
   output logic      [7:0]  PSW_O
);
   logic [31:0] exc_pc_ff;
   logic [31:0] exc_psw_ff;
   logic [31:0] nmi_pc_ff;
   logic [31:0] nmi_psw_ff;
   logic [31:0] cause_ff;
   logic [7:0]  psw_ff;
   logic [7:0]  nxt_psw;
   logic [31:0] rd_mux;
   logic [31:0] sat_res;
   logic        sat_sign;
   logic        int_ok;
   logic        nmi_ok;
   logic        wr_hit;
   csr_pkg::csr_event_t ev;

   csr_rdmux u_rdmux
   (
      .sel_i     (REG_NUM_I),
      .exc_pc_i  (exc_pc_ff),
      .exc_psw_i (exc_psw_ff),
      .nmi_pc_i  (nmi_pc_ff),
      .nmi_psw_i (nmi_psw_ff),
      .cause_i   (cause_ff),
      .psw_i     (psw_ff),
      .data_o    (rd_mux)
   );

   csr_sat u_sat
   (
      .ovf_i  (ALU_OV_I),
      .sign_i (ALU_SIGN_I),
      .raw_i  (ALU_RES_I),
      .res_o  (sat_res),
      .sign_o (sat_sign)
   );

   // Acceptance: NMI service blocks nesting, block flag masks, exception flag does not block
   assign nmi_ok = NMI_REQ_I && !psw_ff[csr_pkg::PSW_NMI_SRV];
   assign int_ok = INT_REQ_I && !psw_ff[csr_pkg::PSW_NMI_SRV] && !psw_ff[csr_pkg::PSW_IRQ_BLK];
   assign wr_hit = SREG_LOAD_I && !(EXC_TAKE_I || nmi_ok || int_ok);

   // Event priority: NMI, exception, maskable interrupt
   always_comb
   begin
      if (nmi_ok)
         ev = csr_pkg::EV_NMI;
      else if (EXC_TAKE_I)
         ev = csr_pkg::EV_EXC;
      else if (int_ok)
         ev = csr_pkg::EV_INT;
      else
         ev = csr_pkg::EV_NONE;
   end

   // Next status word
   always_comb
   begin
      nxt_psw = psw_ff;
      if (FLAG_UPD_I)
      begin
         nxt_psw[csr_pkg::PSW_CARRY] = ALU_CY_I;
         nxt_psw[csr_pkg::PSW_OVF]   = ALU_OV_I;
         nxt_psw[csr_pkg::PSW_Z]  = SAT_OP_I ? (sat_res == 32'h0) : (ALU_RES_I == 32'h0);
         nxt_psw[csr_pkg::PSW_S]  = SAT_OP_I ? sat_sign : ALU_RES_I[31];
         if (SAT_OP_I && ALU_OV_I)
            nxt_psw[csr_pkg::PSW_STICKY_SAT] = 1'b1;
      end
      case (ev)
         csr_pkg::EV_NMI: nxt_psw[csr_pkg::PSW_NMI_SRV] = 1'b1;
         csr_pkg::EV_EXC: nxt_psw[csr_pkg::PSW_EXC_SRV] = 1'b1;
         csr_pkg::EV_INT: nxt_psw[csr_pkg::PSW_IRQ_BLK] = 1'b1;
         default:         ;
      endcase
      if (wr_hit && REG_NUM_I == csr_pkg::REG_PSW)
         nxt_psw = WDATA_I[csr_pkg::PSW_WIDTH-1:0];
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         psw_ff <= csr_pkg::PSW_RESET;
      else
         psw_ff <= nxt_psw;
   end

   // Saved exception pair
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         exc_pc_ff  <= csr_pkg::SAVED_RESET;
         exc_psw_ff <= csr_pkg::SAVED_RESET;
      end
      else if (ev == csr_pkg::EV_EXC || ev == csr_pkg::EV_INT)
      begin
         exc_pc_ff  <= PC_I;
         exc_psw_ff <= {24'h00_0000, psw_ff};
      end
      else if (wr_hit && REG_NUM_I == csr_pkg::REG_SAVED_EXC_PC)
         exc_pc_ff  <= WDATA_I;
      else if (wr_hit && REG_NUM_I == csr_pkg::REG_SAVED_EXC_PSW)
         exc_psw_ff <= WDATA_I;
   end

   // Saved NMI pair
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         nmi_pc_ff  <= csr_pkg::SAVED_RESET;
         nmi_psw_ff <= csr_pkg::SAVED_RESET;
      end
      else if (ev == csr_pkg::EV_NMI)
      begin
         nmi_pc_ff  <= PC_I;
         nmi_psw_ff <= {24'h00_0000, psw_ff};
      end
      else if (wr_hit && REG_NUM_I == csr_pkg::REG_SAVED_NMI_PC)
         nmi_pc_ff  <= WDATA_I;
      else if (wr_hit && REG_NUM_I == csr_pkg::REG_SAVED_NMI_PSW)
         nmi_psw_ff <= WDATA_I;
   end

   // Cause register halves
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cause_ff <= csr_pkg::CAUSE_RESET;
      else if (ev == csr_pkg::EV_NMI)
         cause_ff[31:csr_pkg::CAUSE_NMI_LSB] <= EVENT_CODE_I;
      else if (ev == csr_pkg::EV_EXC || ev == csr_pkg::EV_INT)
         cause_ff[csr_pkg::CAUSE_NMI_LSB-1:0] <= EVENT_CODE_I;
      else if (wr_hit && REG_NUM_I == csr_pkg::REG_CAUSE)
         cause_ff <= WDATA_I;
   end

   // Store path, registered read
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         RDATA_O  <= 32'h0000_0000;
         RVALID_O <= 1'b0;
      end
      else
      begin
         RDATA_O  <= SREG_STORE_I ? rd_mux : 32'h0000_0000;
         RVALID_O <= SREG_STORE_I;
      end
   end

   // Registered outputs
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         SAT_RES_O <= 32'h0000_0000;
         INT_ACK_O <= 1'b0;
         NMI_ACK_O <= 1'b0;
         PSW_O     <= csr_pkg::PSW_RESET;
      end
      else
      begin
         SAT_RES_O <= SAT_OP_I ? sat_res : ALU_RES_I;
         INT_ACK_O <= (ev == csr_pkg::EV_INT);
         NMI_ACK_O <= (ev == csr_pkg::EV_NMI);
         PSW_O     <= nxt_psw;
      end
   end
endmodule
`default_nettype wire

// ==== csr_regs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module csr_chk
(
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        SREG_LOAD_I,
   input wire logic        SREG_STORE_I,
   input wire logic [4:0]  REG_NUM_I,
   input wire logic [31:0] RDATA_O,
   input wire logic        RVALID_O,
   input wire logic        EXC_TAKE_I,
   input wire logic        INT_REQ_I,
   input wire logic        NMI_REQ_I,
   input wire logic        FLAG_UPD_I,
   input wire logic        SAT_OP_I,
   input wire logic        ALU_OV_I,
   input wire logic        ALU_SIGN_I,
   input wire logic [31:0] SAT_RES_O,
   input wire logic        INT_ACK_O,
   input wire logic        NMI_ACK_O,
   input wire logic [7:0]  PSW_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // Saturating update with overflow towards the given sign
   sequence s_sat_ovf(sg);
      FLAG_UPD_I && SAT_OP_I && ALU_OV_I && (ALU_SIGN_I == sg) && !SREG_LOAD_I;
   endsequence
   sequence s_sat_ok;
      FLAG_UPD_I && SAT_OP_I && !ALU_OV_I && !SREG_LOAD_I;
   endsequence
   a_read_answered: assert property (SREG_STORE_I |=> RVALID_O) else $error("read not answered");
   a_reserved_zero: assert property (SREG_STORE_I && REG_NUM_I > 5'h05 |=> RDATA_O == 32'h0)
      else $error("reserved read");
   a_status_upper: assert property (SREG_STORE_I && REG_NUM_I == 5'h05 |=> RDATA_O[31:8] == 24'h0)
      else $error("upper bits");
   a_nmi_sets_np: assert property (NMI_REQ_I && !PSW_O[7] |=> NMI_ACK_O && PSW_O[7]) else $error("nmi ack");
   a_np_blocks_int: assert property (PSW_O[7] |=> !INT_ACK_O) else $error("nested int");
   a_int_sets_id: assert property (INT_REQ_I && PSW_O[7:5] != 3'h0 && !PSW_O[7] && !PSW_O[5] && !NMI_REQ_I
      && !EXC_TAKE_I |=> INT_ACK_O && PSW_O[5]) else $error("int under ep");
   a_exc_sets_ep: assert property (EXC_TAKE_I && !NMI_REQ_I |=> PSW_O[6]) else $error("ep not set");
   a_sat_max: assert property (s_sat_ovf(1'b0) |=> SAT_RES_O == 32'h7fff_ffff && PSW_O[4] && PSW_O[2] && !PSW_O[1])
      else $error("clamp max");
   a_sat_min: assert property (s_sat_ovf(1'b1) |=> SAT_RES_O == 32'h8000_0000 && PSW_O[4] && PSW_O[2] && PSW_O[1])
      else $error("clamp min");
   a_sat_range: assert property (s_sat_ok |=> !PSW_O[2] && PSW_O[4] == $past(PSW_O[4])) else $error("in range");
   a_sat_sticky: assert property (PSW_O[4] && !SREG_LOAD_I |=> PSW_O[4]) else $error("sticky lost");
endmodule
bind csr_regs csr_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .SREG_LOAD_I(SREG_LOAD_I), .SREG_STORE_I(SREG_STORE_I),
   .REG_NUM_I(REG_NUM_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .EXC_TAKE_I(EXC_TAKE_I),
   .INT_REQ_I(INT_REQ_I), .NMI_REQ_I(NMI_REQ_I), .FLAG_UPD_I(FLAG_UPD_I), .SAT_OP_I(SAT_OP_I),
   .ALU_OV_I(ALU_OV_I), .ALU_SIGN_I(ALU_SIGN_I), .SAT_RES_O(SAT_RES_O), .INT_ACK_O(INT_ACK_O),
   .NMI_ACK_O(NMI_ACK_O), .PSW_O(PSW_O));
`default_nettype wire

// ==== tb_cpu_system_register_set.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_system_register_set;
   logic        clk, rst_n, sload, sstore, exc, irq, nmi, fupd, satop, cy, ov, sg, rvalid, iack, nack;
   logic [4:0]  num;
   logic [15:0] code;
   logic [31:0] wdata, pc, res, rdata, satres;
   logic [7:0]  program_status_word;
   int          mismatches, check_count;
   csr_regs dut (.CLK_I(clk), .RST_N_I(rst_n), .SREG_LOAD_I(sload), .SREG_STORE_I(sstore), .REG_NUM_I(num),
      .WDATA_I(wdata),
      .RDATA_O(rdata), .RVALID_O(rvalid), .EXC_TAKE_I(exc), .INT_REQ_I(irq), .NMI_REQ_I(nmi),
      .EVENT_CODE_I(code), .PC_I(pc), .FLAG_UPD_I(fupd), .SAT_OP_I(satop), .ALU_RES_I(res), .ALU_CY_I(cy),
      .ALU_OV_I(ov), .ALU_SIGN_I(sg), .SAT_RES_O(satres), .INT_ACK_O(iack), .NMI_ACK_O(nack), .PSW_O(program_status_word));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] n, input logic [31:0] d);
      @(negedge clk);
      sload = 1'b1;
      num = n;
      wdata = d;
      @(negedge clk);
      sload = 1'b0;
   endtask
   task automatic rd(input logic [4:0] n, input logic [31:0] e);
      @(negedge clk);
      sstore = 1'b1;
      num = n;
      @(negedge clk);
      chk({31'h0, rvalid}, 32'h1);
      chk(rdata, e);
      sstore = 1'b0;
   endtask
   // One event pulse; outputs are looked at by the caller before the next edge
   task automatic ev(input logic e, input logic i, input logic n);
      @(negedge clk);
      {exc, irq, nmi} = {e, i, n};
      @(negedge clk);
      {exc, irq, nmi} = 3'h0;
   endtask
   task automatic fl(input logic s, input logic [31:0] r, input logic c, input logic o, input logic g);
      @(negedge clk);
      {fupd, satop, res, cy, ov, sg} = {1'b1, s, r, c, o, g};
      @(negedge clk);
      fupd = 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      {rst_n, sload, sstore, exc, irq, nmi, fupd, satop, cy, ov, sg} = 11'h0;
      {num, code, wdata, pc, res} = 'h0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      rd(5'h05, 32'h20);
      rd(5'h04, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         wr(i[4:0], 32'h1111_1111 * (i + 1));
         rd(i[4:0], 32'h1111_1111 * (i + 1));
      end
      wr(5'h06, 32'hffff_ffff);
      rd(5'h06, 32'h0);
      wr(5'h1f, 32'ha5a5_a5a5);
      rd(5'h1f, 32'h0);
      wr(5'h05, 32'hffff_ffff);
      rd(5'h05, 32'hff);
      wr(5'h05, 32'h0);
      pc = 32'h100;
      code = 16'h0010;
      ev(1'b0, 1'b0, 1'b1);
      chk({nack, program_status_word}, 9'h180);
      rd(5'h02, 32'h100);
      rd(5'h03, 32'h0);
      rd(5'h04, 32'h0010_5555);
      ev(1'b0, 1'b1, 1'b1);
      chk({nack, iack}, 2'h0);
      wr(5'h05, 32'h40);
      pc = 32'h200;
      code = 16'h0080;
      ev(1'b0, 1'b1, 1'b0);
      chk({iack, program_status_word}, 9'h160);
      rd(5'h00, 32'h200);
      rd(5'h01, 32'h40);
      rd(5'h04, 32'h0010_0080);
      ev(1'b0, 1'b1, 1'b0);
      chk(iack, 1'b0);
      wr(5'h05, 32'h0);
      pc = 32'h300;
      ev(1'b1, 1'b0, 1'b0);
      chk(program_status_word[6], 1'b1);
      rd(5'h00, 32'h300);
      wr(5'h05, 32'h0);
      fl(1'b0, 32'h0, 1'b1, 1'b0, 1'b0);
      chk(program_status_word[3:0], 4'h9);
      fl(1'b0, 32'h8000_0000, 1'b0, 1'b1, 1'b1);
      chk(program_status_word[3:0], 4'h6);
      fl(1'b1, 32'h8000_0001, 1'b0, 1'b1, 1'b0);
      chk(satres, 32'h7fff_ffff);
      chk(program_status_word[4:0], 5'h14);
      fl(1'b1, 32'h5, 1'b0, 1'b0, 1'b0);
      chk(satres, 32'h5);
      chk(program_status_word[4:0], 5'h10);
      fl(1'b1, 32'h7fff_0000, 1'b0, 1'b1, 1'b1);
      chk(satres, 32'h8000_0000);
      chk(program_status_word[4:0], 5'h16);
      wr(5'h05, 32'h0);
      rd(5'h05, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
